/* drive_fault_pkg.sv */
// constants shared by the drive fault monitor and its persistence timers
`default_nettype none
package drive_fault_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int TIME_W = 16;

  localparam int STALL_TIME_S = 3;
  localparam logic [TIME_W-1:0] STALL_LIMIT_MS =
    TIME_W'(STALL_TIME_S * MS_PER_S);

  localparam logic [1:0] SEL_DETECT_MAX = 2'h2;
  localparam logic [2:0] CTRL_CLOSED_VF = 3'h1;
  localparam logic [2:0] CTRL_OPEN_VECTOR = 3'h2;
  localparam logic [2:0] CTRL_CLOSED_VECTOR = 3'h3;
  localparam logic [1:0] FBK_HANDLE_FAULT = 2'h2;

  localparam int NUM_EXT = 5;
  localparam int NUM_FAULTS = 11;
  localparam int NUM_TIMERS = 3;
  localparam int TMR_ENC = 0;
  localparam int TMR_SPD = 1;
  localparam int TMR_STALL = 2;

  localparam int IDX_ENC = 0;
  localparam int IDX_SPD = 1;
  localparam int IDX_SERVO = 2;
  localparam int IDX_STALL = 3;
  localparam int IDX_FBK = 4;
  localparam int IDX_OPT = 5;
  localparam int IDX_EXT3 = 6;

  // displayed code is fault index plus one, zero means no fault
  typedef logic [3:0] fault_code_t;
  localparam fault_code_t CODE_NONE = 4'h0;

endpackage
`default_nettype wire

/* persist_if.sv */
// condition, time base and expiry between monitor and persistence timer
`timescale 1ns/1ps
`default_nettype none
interface persist_if #(parameter int TW = 16);
  logic cond;
  logic tick;
  logic strict;
  logic [TW-1:0] limit;
  logic expired;
  modport owner (output cond, tick, strict, limit, input expired);
  modport timer (input cond, tick, strict, limit, output expired);
endinterface
`default_nettype wire

/* persist_timer.sv */
// counts time ticks while a condition holds, flags when the limit is reached, or passed if strict
`timescale 1ns/1ps
`default_nettype none
module persist_timer
  import drive_fault_pkg::*;
#(
  parameter int TW = TIME_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  persist_if.timer bus
);

  logic [TW-1:0] cnt_q;
  logic [TW-1:0] cnt_d;
  wire cnt_full = &cnt_q;
  wire over_limit = cnt_q > bus.limit;
  wire at_limit = cnt_q >= bus.limit;

  // any break in the condition restarts the count
  assign cnt_d = !bus.cond ? '0 :
                 (bus.tick && !cnt_full) ? cnt_q + TW'(1) : cnt_q;
  assign bus.expired = bus.cond && (bus.strict ? over_limit : at_limit);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end

  chk_count_restart: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !bus.cond |=> cnt_q == '0)
    else $error("timer count not restarted");

  chk_expiry_count: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    bus.expired |-> cnt_q >= bus.limit)
    else $error("expiry before limit reached");

endmodule
`default_nettype wire

/* drive_fault_monitor.sv */
// drive fault monitor: detects, latches and reports drive fault codes
// Behaviour
// - encoder-open fault if enabled and no pulse for longer than loss time
// - speed-deviation fault if deviation above level longer than set time
// - zero-servo fault when position leaves held value during zero-servo
// - out-of-control fault after torque limit held 3 s in open-vector stop
// - feedback-loss fault when handling is 2 and feedback below loss level
// - option-card fault while card asserts its external fault indication
// - own external fault per terminal three to seven, programmed and active
`timescale 1ns/1ps
`default_nettype none
module drive_fault_monitor
  import drive_fault_pkg::*;
#(
  parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic encoder_pulse_i,
  input wire logic [1:0] encoder_loss_select_i,
  input wire logic [2:0] control_method_select_i,
  input wire logic [TIME_W-1:0] encoder_loss_time_i,
  input wire logic [1:0] deviation_select_i,
  input wire logic [15:0] speed_deviation_i,
  input wire logic [15:0] deviation_level_i,
  input wire logic [TIME_W-1:0] deviation_time_i,
  input wire logic zero_servo_active_i,
  input wire logic [31:0] motor_position_i,
  input wire logic decel_stop_i,
  input wire logic torque_limit_i,
  input wire logic [1:0] feedback_loss_handling_i,
  input wire logic [15:0] pid_feedback_i,
  input wire logic [15:0] feedback_loss_level_i,
  input wire logic option_card_fault_i,
  input wire logic [NUM_EXT-1:0] ext_fault_terminal_i,
  input wire logic [NUM_EXT-1:0] ext_fault_program_i,
  input wire logic fault_reset_i,
  output logic [NUM_FAULTS-1:0] fault_flags_o,
  output logic [3:0] fault_code_o,
  output logic fault_active_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and encoder edge

  localparam int NSYNC = NUM_EXT + 2;
  logic [NSYNC-1:0] sync_a_q;
  logic [NSYNC-1:0] sync_b_q;
  logic enc_prev_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_a_q <= '0;
      sync_b_q <= '0;
      enc_prev_q <= 1'b0;
    end else begin
      sync_a_q <= {ext_fault_terminal_i, option_card_fault_i, encoder_pulse_i};
      sync_b_q <= sync_a_q;
      enc_prev_q <= sync_b_q[0];
    end
  end

  wire enc_edge = sync_b_q[0] && !enc_prev_q;
  wire opt_fault_s = sync_b_q[1];
  wire [NUM_EXT-1:0] ext_term_s = sync_b_q[NSYNC-1:2];

  ////////////////////////////////////////////////////////////////////////////
  // millisecond time base

  localparam int TCW = $clog2(TICK_CYCLES + 1);
  logic [TCW-1:0] tick_cnt_q;
  wire tick_w = tick_cnt_q == TCW'(TICK_CYCLES - 1);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) tick_cnt_q <= '0;
    else tick_cnt_q <= tick_w ? '0 : tick_cnt_q + TCW'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // detection enables and persistence timers

  wire closed_loop = (control_method_select_i == CTRL_CLOSED_VF) ||
                     (control_method_select_i == CTRL_CLOSED_VECTOR);
  wire enc_en = (encoder_loss_select_i <= SEL_DETECT_MAX) && closed_loop;
  wire spd_en = (deviation_select_i <= SEL_DETECT_MAX) && closed_loop;
  wire spd_over = speed_deviation_i > deviation_level_i;
  wire stall_cond = decel_stop_i && torque_limit_i &&
                    (control_method_select_i == CTRL_OPEN_VECTOR);

  persist_if #(.TW(TIME_W)) tmr_if [NUM_TIMERS] ();

  assign tmr_if[TMR_ENC].cond = enc_en && !enc_edge;
  assign tmr_if[TMR_ENC].strict = 1'b1;
  assign tmr_if[TMR_ENC].limit = encoder_loss_time_i;
  assign tmr_if[TMR_SPD].cond = spd_en && spd_over;
  assign tmr_if[TMR_SPD].strict = 1'b1;
  assign tmr_if[TMR_SPD].limit = deviation_time_i;
  assign tmr_if[TMR_STALL].cond = stall_cond;
  assign tmr_if[TMR_STALL].strict = 1'b0;
  assign tmr_if[TMR_STALL].limit = STALL_LIMIT_MS;

  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
      assign tmr_if[g].tick = tick_w;
      persist_timer #(.TW(TIME_W)) u_tmr (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .bus(tmr_if[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // zero-servo position hold

  logic servo_arm_q;
  logic [31:0] hold_pos_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      servo_arm_q <= 1'b0;
      hold_pos_q <= '0;
    end else begin
      servo_arm_q <= zero_servo_active_i;
      if (zero_servo_active_i && !servo_arm_q) hold_pos_q <= motor_position_i;
    end
  end

  wire servo_moved = servo_arm_q && zero_servo_active_i &&
                     (motor_position_i != hold_pos_q);

  ////////////////////////////////////////////////////////////////////////////
  // raw fault conditions

  wire [NUM_FAULTS-1:0] cond_w;
  assign cond_w[IDX_ENC] = tmr_if[TMR_ENC].expired;
  assign cond_w[IDX_SPD] = tmr_if[TMR_SPD].expired;
  assign cond_w[IDX_SERVO] = servo_moved;
  assign cond_w[IDX_STALL] = tmr_if[TMR_STALL].expired;
  assign cond_w[IDX_FBK] =
    (feedback_loss_handling_i == FBK_HANDLE_FAULT) &&
    (pid_feedback_i < feedback_loss_level_i);
  assign cond_w[IDX_OPT] = opt_fault_s;
  assign cond_w[IDX_EXT3 +: NUM_EXT] =
    ext_term_s & ext_fault_program_i;

  ////////////////////////////////////////////////////////////////////////////
  // fault latches and code

  logic [NUM_FAULTS-1:0] latched_q;
  logic [NUM_FAULTS-1:0] latched_d;
  fault_code_t code_d;

  // a live condition always sets its flag, so the set wins over reset
  assign latched_d = cond_w | (fault_reset_i ? '0 : latched_q);

  always_comb begin
    code_d = CODE_NONE;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (latched_d[i]) code_d = fault_code_t'(i + 1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latched_q <= '0;
      fault_code_o <= CODE_NONE;
    end else begin
      latched_q <= latched_d;
      fault_code_o <= code_d;
    end
  end

  assign fault_flags_o = latched_q;
  assign fault_active_o = |latched_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_clear_req;
    fault_reset_i && !(|cond_w);
  endsequence

  sequence s_pin_rise(logic p);
    $rose(p) ##2 1'b1;
  endsequence

  chk_enc_open_gate: assert property (
    cond_w[IDX_ENC] |-> enc_en)
    else $error("encoder-open raised while detection disabled");

  chk_speed_gate: assert property (
    cond_w[IDX_SPD] |-> spd_en && spd_over)
    else $error("deviation fault without enabled excess");

  chk_servo_move: assert property (
    servo_arm_q && zero_servo_active_i &&
    motor_position_i != hold_pos_q |=> latched_q[IDX_SERVO])
    else $error("zero-servo movement not latched");

  chk_stall_mode: assert property (
    !stall_cond |-> !cond_w[IDX_STALL])
    else $error("out-of-control raised without torque limit");

  chk_feedback_level: assert property (
    (feedback_loss_handling_i == FBK_HANDLE_FAULT) &&
    (pid_feedback_i < feedback_loss_level_i) |=> latched_q[IDX_FBK])
    else $error("feedback loss missed");

  chk_opt_fault: assert property (
    s_pin_rise(option_card_fault_i) |=> latched_q[IDX_OPT])
    else $error("option-card fault not latched");

  chk_ext_terminal: assert property (
    1'b1 |=> (latched_q[IDX_EXT3 +: NUM_EXT] & $past(ext_term_s) &
    $past(ext_fault_program_i)) ==
    ($past(ext_term_s) & $past(ext_fault_program_i)))
    else $error("terminal fault not latched");

  chk_latch_hold: assert property (
    !fault_reset_i |=> (latched_q & $past(latched_q)) == $past(latched_q))
    else $error("fault flag dropped without reset");

  chk_clear_done: assert property (
    s_clear_req |=> latched_q == '0 && fault_code_o == CODE_NONE)
    else $error("fault reset left a flag");

  chk_code_shown: assert property (
    fault_active_o |-> fault_code_o != CODE_NONE)
    else $error("latched fault without code");

endmodule
`default_nettype wire

/* far_side_model.sv */
// encoder, option card and terminal contacts seen from the drive side
`timescale 1ns/1ps
`default_nettype none
module far_side_model
  import drive_fault_pkg::*;
(
  input wire logic clk_i,
  input wire logic spin_i,
  input wire logic card_fault_i,
  input wire logic [NUM_EXT-1:0] contacts_i,
  output logic encoder_pulse_o,
  output logic option_card_fault_o,
  output logic [NUM_EXT-1:0] ext_fault_terminal_o
);
  logic [2:0] phase_q = 3'h0;
  always @(posedge clk_i) begin
    phase_q <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
  end
  // one pulse per six clocks while turning, line low at standstill
  assign encoder_pulse_o = spin_i && (phase_q < 3'h3);
  // card holds its indication for as long as the condition lasts
  assign option_card_fault_o = card_fault_i;
  assign ext_fault_terminal_o = contacts_i;
endmodule
`default_nettype wire

/* test_drive_fault_monitor.sv */
// self-checking bench for the drive fault monitor
`timescale 1ns/1ps
`default_nettype none
module test_drive_fault_monitor;
  import drive_fault_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, spin = 1'b0, card = 1'b0;
  logic enc, opt, zs = 1'b0, dstop = 1'b0, tlim = 1'b0, frst = 1'b0;
  logic [1:0] esel = 2'h3, dsel = 2'h3, fblh = 2'h0;
  logic [2:0] ctrl = 3'h0;
  logic [15:0] etime = 16'h0002, sdev = 16'h0000, dlvl = 16'h0064;
  logic [15:0] dtime = 16'h0002, fb = 16'h0000, fblvl = 16'h0000;
  logic [31:0] pos = 32'h0000_0005;
  logic [NUM_EXT-1:0] cont = '0, term, prog = '0;
  logic [NUM_FAULTS-1:0] flags;
  logic [3:0] code;
  logic act;
  int bad_count = 0, check_count = 0;
  always #10 clk_i = ~clk_i;
  far_side_model far_side_model_inst (.clk_i(clk_i), .spin_i(spin),
    .card_fault_i(card), .contacts_i(cont), .encoder_pulse_o(enc),
    .option_card_fault_o(opt), .ext_fault_terminal_o(term));
  drive_fault_monitor #(.TICK_CYCLES(4)) drive_fault_monitor_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .encoder_pulse_i(enc),
    .encoder_loss_select_i(esel), .control_method_select_i(ctrl),
    .encoder_loss_time_i(etime), .deviation_select_i(dsel),
    .speed_deviation_i(sdev), .deviation_level_i(dlvl),
    .deviation_time_i(dtime), .zero_servo_active_i(zs),
    .motor_position_i(pos), .decel_stop_i(dstop), .torque_limit_i(tlim),
    .feedback_loss_handling_i(fblh), .pid_feedback_i(fb),
    .feedback_loss_level_i(fblvl), .option_card_fault_i(opt),
    .ext_fault_terminal_i(term), .ext_fault_program_i(prog),
    .fault_reset_i(frst), .fault_flags_o(flags), .fault_code_o(code),
    .fault_active_o(act));
  ////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic flags_are(input logic [31:0] exp);
    check("fault_flags_o", 32'(flags), exp);
  endtask
  task automatic clr;
    {esel, dsel, fblh, ctrl} = {2'h3, 2'h3, 2'h0, 3'h0};
    {zs, dstop, tlim, card, cont, sdev} = '0;
    frst = 1'b1;
    cyc(4);
    frst = 1'b0;
    cyc(1);
    check("fault_active_o", 32'(act), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    cyc(12);
    rst_b_i = 1'b1;
    cyc(2);
    {esel, ctrl} = {2'h0, 3'h2};
    cyc(40);
    flags_are(32'h0);
    {ctrl, spin} = {3'h1, 1'b1};
    cyc(40);
    flags_are(32'h0);
    spin = 1'b0;
    cyc(7);
    flags_are(32'h0);
    cyc(13);
    flags_are(32'h1);
    check("fault_code_o", 32'(code), 32'h1);
    check("fault_active_o", 32'(act), 32'h1);
    clr();
    {dsel, ctrl, sdev} = {2'h2, 3'h3, 16'h0064};
    cyc(40);
    flags_are(32'h0);
    sdev = 16'h0065;
    cyc(7);
    flags_are(32'h0);
    cyc(13);
    flags_are(32'h2);
    clr();
    zs = 1'b1;
    cyc(3);
    flags_are(32'h0);
    pos = 32'h0000_0006;
    cyc(2);
    flags_are(32'h4);
    clr();
    {fblh, fb, fblvl} = {2'h1, 16'h000A, 16'h0014};
    cyc(3);
    flags_are(32'h0);
    fblh = 2'h2;
    cyc(2);
    flags_are(32'h10);
    clr();
    card = 1'b1;
    cyc(5);
    flags_are(32'h20);
    check("fault_code_o", 32'(code), 32'h6);
    frst = 1'b1;
    cyc(2);
    flags_are(32'h20);
    frst = 1'b0;
    card = 1'b0;
    cyc(5);
    flags_are(32'h20);
    check("fault_active_o", 32'(act), 32'h1);
    clr();
    for (int i = 0; i < NUM_EXT; i++) begin
      prog = NUM_EXT'(1 << i);
      cont = '1;
      cyc(5);
      flags_are(32'(1 << (6 + i)));
      check("fault_code_o", 32'(code), 32'(7 + i));
      clr();
    end
    {ctrl, dstop, tlim} = {3'h2, 1'b1, 1'b1};
    cyc(8000);
    tlim = 1'b0;
    cyc(1);
    tlim = 1'b1;
    cyc(11990);
    flags_are(32'h0);
    cyc(20);
    flags_are(32'h8);
    check("fault_code_o", 32'(code), 32'h4);
    clr();
    give_verdict();
  end
  initial begin
    cyc(60000);
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
